/* design/fpi_pkg.sv */
// Package for the front panel indicator controller: states, codes, timing counts.
// Assumes a single 200 MHz standby-powered clock.
package fpi_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_PS     = 5000;
    localparam longint unsigned BLINK_PERIOD_MS = 1000;  // ~1 Hz cadence
    localparam longint unsigned ID_TIMED_S      = 15;    // Timed identify length
    localparam longint unsigned FLICKER_NS      = 50000000; // Disk lamp stretch
    localparam longint unsigned BLINK_HALF_CYC  =
        (BLINK_PERIOD_MS * 1000000000 / 2) / CLK_PERIOD_PS;
    localparam longint unsigned ID_TIMED_CYC    =
        (ID_TIMED_S * 1000000000 * 1000) / CLK_PERIOD_PS;
    localparam longint unsigned FLICKER_CYC     =
        (FLICKER_NS * 1000) / CLK_PERIOD_PS;

    // Platform power state encoding
    typedef enum logic [2:0] {
        PWR_OFF        = 3'h0,
        PWR_LEGACY_ON  = 3'h1,
        PWR_S0         = 3'h2,
        PWR_S1         = 3'h3,
        PWR_S4         = 3'h4,
        PWR_S5         = 3'h5
    } fpi_pwr_t;

    // Health encoding from the management controller
    typedef enum logic [2:0] {
        HLT_OK        = 3'h0,
        HLT_DEGRADED  = 3'h1,
        HLT_NONCRIT   = 3'h2,
        HLT_CRITICAL  = 3'h3,
        HLT_STOP      = 3'h4
    } fpi_health_t;

    // Remote identify command codes
    typedef enum logic [1:0] {
        ID_CMD_OFF    = 2'h0,
        ID_CMD_TIMED  = 2'h1,
        ID_CMD_FOREVER= 2'h2
    } fpi_idcmd_t;

    // Identify lamp mode
    typedef enum logic [1:0] {
        ID_ST_OFF     = 2'h0,
        ID_ST_STEADY  = 2'h1,
        ID_ST_TIMED   = 2'h2,
        ID_ST_FOREVER = 2'h3
    } fpi_idst_t;

    // Remote identify request carrier
    typedef struct packed {
        logic       valid;
        fpi_idcmd_t cmd;
    } fpi_id_req_t;

    // Lamp outputs, active low
    typedef struct packed {
        logic identify_lamp_n;
        logic power_lamp_n;
        logic status_lamp_a_n;
        logic status_lamp_b_n;
        logic disk_activity_lamp_n;
    } fpi_lamps_t;

endpackage

/* design/fpi_panel.sv */
// Front panel indicator controller: identify, power, status and disk lamps,
// front/rear video selection and push-button gating.
// Assumes a free-running standby clock; panel pins are asynchronous.
`timescale 1ns/100ps

// Behaviour
// - Each identify button press toggles identify lamp between off and steady.
// - Timed remote identify blinks the lamp for fifteen seconds, then off.
// - Indefinite remote identify blinks until a later remote request or an identify button press replaces it.
// - Front monitor present disables rear video and enables front video.
// - One source feeds both outputs; front output always wins.
// - Power lamp steady on in legacy power-on or S0.
// - Power lamp blinks in the lightest sleep state.
// - Power lamp dark when off, S4 or S5.
// - Status lamp alternates green and amber while controller initializes.
// - Status lamp encodes health: ok, degraded, critical, non-critical, stop.
// - All blinking runs at about 1 Hz with equal halves.
// - Amber lit or blinking forces the green status element off.
// - Disk lamp flickers on activity pulses, dark otherwise.
// - Disk lamp forced dark when powered off or asleep.
// - Power lamp sleep indication held in standby-powered logic.
// - Power lamp sleep blink restored after abrupt power-down in S1 until firmware clears.
// - Panel buttons ignored until controller initialization finishes.
module fpi_panel
    import fpi_pkg::*;
(
    input  wire logic        core_clk_i,              // Standby clock, 200 MHz
    input  wire logic        rst_n_i,                 // Synchronous reset, active low
    input  wire logic        identify_button_n_i,     // Identify button pin, low pressed
    input  wire logic        power_button_n_i,        // Power button pin, low pressed
    input  wire logic        front_monitor_present_n_i, // Front display attached, low
    input  wire logic        disk_activity_i,         // Drive activity pulse pin
    input  wire logic        mc_init_done_i,          // Controller initialization done
    input  wire fpi_id_req_t id_req_i,                // Remote identify request
    input  wire fpi_pwr_t    pwr_state_i,             // Platform power state
    input  wire logic        main_power_good_i,       // Main power present
    input  wire logic        fw_clear_i,              // Firmware clears held lamp state
    input  wire fpi_health_t health_i,                // Health from controller
    output logic             power_on_req_o,          // Gated power button pulse
    output fpi_lamps_t       lamps_o,                 // Lamp drives, active low
    output logic             front_video_en_o,        // Front video enable
    output logic             rear_video_en_o          // Rear video enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sync1_q <= 4'hF;
            sync2_q <= 4'hF;
        end else begin
            sync1_q <= {identify_button_n_i, power_button_n_i,
                        front_monitor_present_n_i, ~disk_activity_i};
            sync2_q <= sync1_q;
        end
    end
    logic id_btn_n_s, pwr_btn_n_s, front_n_s, disk_n_s;
    assign id_btn_n_s  = sync2_q[3];
    assign pwr_btn_n_s = sync2_q[2];
    assign front_n_s   = sync2_q[1];
    assign disk_n_s    = sync2_q[0];

    // Press edges on synchronised levels
    logic id_btn_prev_q, pwr_btn_prev_q;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            id_btn_prev_q  <= 1'b1;
            pwr_btn_prev_q <= 1'b1;
        end else begin
            id_btn_prev_q  <= id_btn_n_s;
            pwr_btn_prev_q <= pwr_btn_n_s;
        end
    end
    logic id_press, pwr_press;
    assign id_press  = id_btn_prev_q & ~id_btn_n_s & mc_init_done_i;
    assign pwr_press = pwr_btn_prev_q & ~pwr_btn_n_s & mc_init_done_i;

    // Power button pulse out
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            power_on_req_o <= 1'b0;
        end else begin
            power_on_req_o <= pwr_press;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Blink cadence: half-period counter and phase
    localparam int BW = $clog2(BLINK_HALF_CYC);
    localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_HALF_CYC - 1);
    logic [BW-1:0] blink_cnt_q;
    logic          blink_q;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b1;   // Phase starts lit so a blink begun in the first half period after reset shows at once
        end else if (blink_cnt_q == BLINK_LAST) begin
            blink_cnt_q <= '0;
            blink_q     <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Identify lamp mode machine
    localparam int IW = $clog2(ID_TIMED_CYC);
    localparam logic [IW-1:0] ID_LAST = IW'(ID_TIMED_CYC - 1);
    fpi_idst_t     id_st_q;
    logic [IW-1:0] id_cnt_q;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            id_st_q  <= ID_ST_OFF;
            id_cnt_q <= '0;
        end else if (id_req_i.valid) begin
            id_cnt_q <= '0;
            case (id_req_i.cmd)
                ID_CMD_TIMED:   id_st_q <= ID_ST_TIMED;
                ID_CMD_FOREVER: id_st_q <= ID_ST_FOREVER;
                default:        id_st_q <= ID_ST_OFF;
            endcase
        end else if (id_press) begin
            id_st_q <= (id_st_q == ID_ST_STEADY) ? ID_ST_OFF : ID_ST_STEADY;
        end else begin
            case (id_st_q)
                ID_ST_TIMED: begin
                    if (id_cnt_q == ID_LAST) begin
                        id_st_q <= ID_ST_OFF;
                    end else begin
                        id_cnt_q <= id_cnt_q + 1'b1;
                    end
                end
                default: id_cnt_q <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power lamp with standby-held state
    logic pwr_hold_q;  // Lamp pattern kept across abrupt power-down
    logic pwr_live;
    logic pwr_lamp;
    always_comb begin
        case (pwr_state_i)
            PWR_LEGACY_ON, PWR_S0: pwr_live = 1'b1;
            PWR_S1:                pwr_live = blink_q;
            default:               pwr_live = 1'b0;
        endcase
    end
    // Remember whether the last live state was sleep
    logic pwr_sleep_q;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pwr_sleep_q <= 1'b0;
            pwr_hold_q  <= 1'b0;
        end else if (!main_power_good_i && pwr_state_i == PWR_S1) begin
            pwr_sleep_q <= 1'b1;
            pwr_hold_q  <= 1'b1;
        end else if (fw_clear_i) begin
            pwr_hold_q  <= 1'b0;
        end else if (main_power_good_i && !pwr_hold_q) begin
            pwr_sleep_q <= (pwr_state_i == PWR_S1);
        end
    end
    assign pwr_lamp = pwr_hold_q ? (pwr_sleep_q & blink_q) : pwr_live;

    ////////////////////////////////////////////////////////////////////////////
    // Status lamp: a = green, b = amber
    logic st_green, st_amber;
    always_comb begin
        st_green = 1'b0;
        st_amber = 1'b0;
        if (!mc_init_done_i) begin
            st_green = blink_q;
            st_amber = ~blink_q;
        end else begin
            case (health_i)
                HLT_OK:       st_green = 1'b1;
                HLT_DEGRADED: st_green = blink_q;
                HLT_CRITICAL: st_amber = 1'b1;
                HLT_NONCRIT:  st_amber = blink_q;
                default:      st_green = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Disk lamp stretch so each pulse is visible
    localparam int FW = $clog2(FLICKER_CYC + 1);
    localparam logic [FW-1:0] FLICK_LOAD = FW'(FLICKER_CYC);
    logic [FW-1:0] disk_cnt_q;
    logic          disk_awake;
    assign disk_awake = (pwr_state_i == PWR_S0) || (pwr_state_i == PWR_LEGACY_ON);
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            disk_cnt_q <= '0;
        end else if (!disk_awake) begin
            disk_cnt_q <= '0;
        end else if (!disk_n_s) begin
            disk_cnt_q <= FLICK_LOAD;
        end else if (disk_cnt_q != '0) begin
            disk_cnt_q <= disk_cnt_q - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered lamp and video outputs
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            lamps_o          <= '1;
            front_video_en_o <= 1'b0;
            rear_video_en_o  <= 1'b1;
        end else begin
            lamps_o.identify_lamp_n      <= ~((id_st_q == ID_ST_STEADY) |
                ((id_st_q == ID_ST_TIMED || id_st_q == ID_ST_FOREVER) & blink_q));
            lamps_o.power_lamp_n         <= ~pwr_lamp;
            lamps_o.status_lamp_a_n      <= ~(st_green & ~st_amber);
            lamps_o.status_lamp_b_n      <= ~st_amber;
            lamps_o.disk_activity_lamp_n <= ~(disk_awake && disk_cnt_q != '0);
            front_video_en_o             <= ~front_n_s;
            rear_video_en_o              <= front_n_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_timed_req;
        id_req_i.valid && id_req_i.cmd == ID_CMD_TIMED;
    endsequence

    a_video_exclusive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !(front_video_en_o && rear_video_en_o))
        else $error("front and rear video both enabled");
    a_front_priority: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !front_n_s |=> front_video_en_o && !rear_video_en_o)
        else $error("front monitor did not take video");
    a_timed_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_timed_req |=> id_st_q == ID_ST_TIMED && id_cnt_q == '0)
        else $error("timed identify did not start");
    a_forever_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        id_st_q == ID_ST_FOREVER && !id_req_i.valid |=> id_st_q == ID_ST_FOREVER)
        else $error("indefinite identify stopped by itself");
    a_button_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !$past(mc_init_done_i) |-> !power_on_req_o)
        else $error("power press passed before init done");
    a_amber_wins: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !lamps_o.status_lamp_b_n |-> lamps_o.status_lamp_a_n)
        else $error("green lit with amber");
    a_disk_sleep: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pwr_state_i == PWR_S1 |=> lamps_o.disk_activity_lamp_n)
        else $error("disk lamp lit in sleep");
    a_power_s0: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !pwr_hold_q && pwr_state_i == PWR_S0 |=> !lamps_o.power_lamp_n)
        else $error("power lamp dark in S0");
    a_power_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !pwr_hold_q && pwr_state_i == PWR_S5 |=> lamps_o.power_lamp_n)
        else $error("power lamp lit in S5");
    a_blink_half: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $changed(blink_q) |-> $past(blink_cnt_q) == BLINK_LAST)
        else $error("blink phase changed off cadence");

endmodule // fpi_panel

/* verif/fpi_mc_model.sv */
// Behavioural model of the management controller and the chipset power state lines.
// Assumes the bench calls its tasks; every line changes on the falling clock edge.
`timescale 1ns/100ps
module fpi_mc_model
    import fpi_pkg::*;
(
    input  wire logic   core_clk_i,        // Standby clock
    output logic        mc_init_done_o,    // Initialization finished
    output fpi_id_req_t id_req_o,          // Remote identify request
    output fpi_pwr_t    pwr_state_o,       // Platform power state
    output logic        main_power_good_o, // Main power present
    output logic        fw_clear_o,        // Firmware clear of held lamp state
    output fpi_health_t health_o           // Health code
);
    // Still initializing, platform off, at time zero
    initial begin
        mc_init_done_o    = 1'h0;
        id_req_o          = 3'h0;
        pwr_state_o       = PWR_OFF;
        main_power_good_o = 1'h0;
        fw_clear_o        = 1'h0;
        health_o          = HLT_OK;
    end

    // Initialization completes some time after standby power
    task automatic finish_init();
        @(negedge core_clk_i);
        mc_init_done_o = 1'h1;
    endtask

    // One-cycle identify request; the command field does not hold afterwards
    task automatic send_id(input fpi_idcmd_t cmd);
        @(negedge core_clk_i);
        id_req_o = {1'h1, cmd};
        @(negedge core_clk_i);
        id_req_o = {1'h0, ~cmd};
    endtask

    // Main power is present while running or in the lightest sleep state
    task automatic set_state(input fpi_pwr_t st, input fpi_health_t h);
        @(negedge core_clk_i);
        pwr_state_o       = st;
        health_o          = h;
        main_power_good_o = (st == PWR_LEGACY_ON) || (st == PWR_S0) || (st == PWR_S1);
    endtask

    // Main power drops while the chipset still reports the lightest sleep state
    task automatic lose_power();
        @(negedge core_clk_i);
        main_power_good_o = 1'h0;
    endtask

    // One-cycle firmware clear of the held power lamp state
    task automatic clear_hold();
        @(negedge core_clk_i);
        fw_clear_o = 1'h1;
        @(negedge core_clk_i);
        fw_clear_o = 1'h0;
    endtask
endmodule // fpi_mc_model

/* verif/fpi_panel_tb.sv */
// Self-checking bench for the front panel indicator controller.
// Assumes package counts at full size, so long blink and identify spans stay unobserved.
`timescale 1ns/100ps
module fpi_panel_tb
    import fpi_pkg::*;
;
    logic core_clk, rst_n, id_btn_n, pwr_btn_n, mon_n, disk_act;
    logic init_done, pg, fw_clr, req, front_en, rear_en;
    fpi_id_req_t id_req;
    fpi_pwr_t    pwr;
    fpi_health_t hlt;
    fpi_lamps_t  lamps;
    int          err_total, comparisons, pulses;
    fpi_pwr_t    st_tab[5] = '{PWR_OFF, PWR_LEGACY_ON, PWR_S0, PWR_S4, PWR_S5};
    logic [4:0]  pl_exp = 5'h19;
    fpi_health_t h_tab[5] = '{HLT_OK, HLT_CRITICAL, HLT_STOP, HLT_DEGRADED, HLT_NONCRIT};
    logic [1:0]  h_exp[5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2};
    logic [1:0]  h_msk[5] = '{2'h3, 2'h3, 2'h3, 2'h1, 2'h2};

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and design instances
    initial begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end

    fpi_panel fpi_panel_inst (.core_clk_i(core_clk), .rst_n_i(rst_n),
        .identify_button_n_i(id_btn_n), .power_button_n_i(pwr_btn_n),
        .front_monitor_present_n_i(mon_n), .disk_activity_i(disk_act),
        .mc_init_done_i(init_done), .id_req_i(id_req), .pwr_state_i(pwr),
        .main_power_good_i(pg), .fw_clear_i(fw_clr), .health_i(hlt),
        .power_on_req_o(req), .lamps_o(lamps), .front_video_en_o(front_en),
        .rear_video_en_o(rear_en));

    fpi_mc_model fpi_mc_model_inst (.core_clk_i(core_clk), .mc_init_done_o(init_done),
        .id_req_o(id_req), .pwr_state_o(pwr), .main_power_good_o(pg),
        .fw_clear_o(fw_clr), .health_o(hlt));

    // Counts power-on pulses
    always @(negedge core_clk) begin
        if (req === 1'h1) pulses++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Holds a button low long enough to pass the synchronizer, then releases it
    task automatic press(input bit pwr_btn);
        if (pwr_btn) pwr_btn_n = 1'h0;
        else id_btn_n = 1'h0;
        cyc(6);
        pwr_btn_n = 1'h1;
        id_btn_n  = 1'h1;
        cyc(6);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        {rst_n, disk_act} = 2'h0;
        {id_btn_n, pwr_btn_n, mon_n} = 3'h7;
        cyc(3);
        chk(lamps, 5'h1F);
        chk({2'h0, front_en, rear_en, req}, 5'h02);
        rst_n = 1'h1;
        cyc(3);
        chk({4'h0, lamps.status_lamp_a_n ^ lamps.status_lamp_b_n}, 5'h01);
        pulses = 0;
        press(1'b1);
        press(1'b0);
        chk(pulses[4:0], 5'h00);
        chk({4'h0, lamps.identify_lamp_n}, 5'h01);
        fpi_mc_model_inst.finish_init();
        fpi_mc_model_inst.set_state(PWR_S0, HLT_OK);
        cyc(3);
        press(1'b1);
        chk(pulses[4:0], 5'h01);
        press(1'b0);
        cyc(20);
        chk({4'h0, lamps.identify_lamp_n}, 5'h00);
        press(1'b0);
        chk({4'h0, lamps.identify_lamp_n}, 5'h01);
        // Power lamp across every steady state, no disk traffic
        for (int i = 0; i < 5; i++) begin
            fpi_mc_model_inst.set_state(st_tab[i], HLT_OK);
            cyc(3);
            chk({4'h0, lamps.power_lamp_n}, {4'h0, pl_exp[i]});
            chk({4'h0, lamps.disk_activity_lamp_n}, 5'h01);
        end
        // Status lamp health codes, amber blanks green
        for (int i = 0; i < 5; i++) begin
            fpi_mc_model_inst.set_state(PWR_S0, h_tab[i]);
            cyc(3);
            chk({3'h0, {lamps.status_lamp_a_n, lamps.status_lamp_b_n} & h_msk[i]},
                {3'h0, h_exp[i] & h_msk[i]});
        end
        disk_act = 1'h1;
        cyc(2);
        disk_act = 1'h0;
        cyc(4);
        chk({4'h0, lamps.disk_activity_lamp_n}, 5'h00);
        fpi_mc_model_inst.set_state(PWR_S1, HLT_OK);
        cyc(3);
        chk({4'h0, lamps.disk_activity_lamp_n}, 5'h01);
        chk({4'h0, lamps.power_lamp_n}, 5'h00);
        // Abrupt power loss in sleep: lamp state held until firmware clears it
        fpi_mc_model_inst.lose_power();
        fpi_mc_model_inst.set_state(PWR_OFF, HLT_OK);
        cyc(3);
        chk({4'h0, lamps.power_lamp_n}, 5'h00);
        fpi_mc_model_inst.clear_hold();
        cyc(3);
        chk({4'h0, lamps.power_lamp_n}, 5'h01);
        mon_n = 1'h0;
        cyc(5);
        chk({3'h0, front_en, rear_en}, 5'h02);
        mon_n = 1'h1;
        cyc(5);
        chk({3'h0, front_en, rear_en}, 5'h01);
        // Remote identify ends any mode on an off request
        fpi_mc_model_inst.set_state(PWR_S0, HLT_OK);
        fpi_mc_model_inst.send_id(ID_CMD_FOREVER);
        cyc(2);
        chk({4'h0, lamps.identify_lamp_n}, 5'h00);
        fpi_mc_model_inst.send_id(ID_CMD_OFF);
        cyc(3);
        chk({4'h0, lamps.identify_lamp_n}, 5'h01);
        press(1'b0);
        fpi_mc_model_inst.send_id(ID_CMD_OFF);
        cyc(3);
        chk({4'h0, lamps.identify_lamp_n}, 5'h01);
        fpi_mc_model_inst.send_id(ID_CMD_TIMED);
        fpi_mc_model_inst.send_id(ID_CMD_TIMED);
        cyc(2);
        chk({4'h0, lamps.identify_lamp_n}, 5'h00);
        fpi_mc_model_inst.send_id(ID_CMD_OFF);
        cyc(3);
        chk({4'h0, lamps.identify_lamp_n}, 5'h01);
        give_verdict();
    end
endmodule // fpi_panel_tb
